/* src/spi_read_response_framer.sv */
// spi client that frames register read, sensor data and error responses
`timescale 1ns/1ps
// Operation
// R1: read answer is code, basic flags, two zeros, high byte, low byte, crc
// R2: sensor answer holds sample, extension, detail flags, crc; error with data forces flags 11
// R3: error without data uses code 0000, flags 11, zero data, detail flags, crc
// R4: read decodes only upper seven address bits, selecting a byte pair
// R5: read answer leaves in the frame after the request frame
// R6: normal read answer only when no protocol error on the request
// R7: normal read answer only when no output verification error
// R8: on either error send the error answer with cause in detail flags
// R9: register pair sampled when select rises ending the request frame
// R10: 32-bit frames, msb first, clock idle low, sample rise, shift fall
// R11: host sends read as code 1100, address in bits 23..16, crc
// R12: read answer command field is 0110
// R13: clock and data ignored while select is high
// R14: crc covers bits 31..8 with configurable polynomial and seed
// R15: first frame after reset gets the no-data error layout
module spi_read_response_framer #(
  parameter logic [7:0] CRC_POLY = spi_resp_pkg::CRC_POLY_DEF,
  parameter logic [7:0] CRC_SEED = spi_resp_pkg::CRC_SEED_DEF
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // spi pins
  input  wire logic        sclk,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  // register pair lookup
  output logic [6:0]       reg_addr,
  input  wire logic [15:0] reg_pair,
  // sensor data source
  input  wire logic        sense_req,
  input  wire logic [3:0]  sense_cmd,
  input  wire logic [1:0]  basic_flags,
  input  wire logic [11:0] sample_value,
  input  wire logic [3:0]  sample_ext,
  input  wire logic [1:0]  detail_flags,
  // error checks
  input  wire logic        proto_err,
  input  wire logic        outchk_err,
  input  wire logic [1:0]  err_detail,
  // frame event
  output logic             frame_done
);

  typedef struct packed {
    logic [1:0]  sclk_s;
    logic [1:0]  sel_s;
    logic [1:0]  mosi_s;
    logic        sclk_d;
    logic        sel_d;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [5:0]  cnt;
    logic [6:0]  addr;
    logic        miso;
    logic        oe;
    logic        done;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [7:0] crc24(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      if (c[7] ^ d[i]) c = {c[6:0], 1'b0} ^ CRC_POLY;
      else c = {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc24

  function automatic logic [31:0] seal(input logic [23:0] body);
    return {body, crc24(body)}; // R14
  endfunction : seal

  ////////////////////////////////////////////////////////////////////////////
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [23:0] body;

  // edge finding on synchronised pins
  always_comb begin
    rise  = st_r.sclk_s[1] & ~st_r.sclk_d & ~st_r.sel_s[1]; // R13
    fall  = ~st_r.sclk_s[1] & st_r.sclk_d & ~st_r.sel_s[1]; // R13
    start = ~st_r.sel_s[1] & st_r.sel_d;
    stop  = st_r.sel_s[1] & ~st_r.sel_d;
  end

  // choose next outgoing body at frame end
  always_comb begin
    body = {spi_resp_pkg::CMD_ERR, spi_resp_pkg::FLAGS_ERR, 16'h0000, err_detail}; // R3
    if (st_r.rx[spi_resp_pkg::CMD_HI:spi_resp_pkg::CMD_LO] == spi_resp_pkg::CMD_RD_REQ) begin // R11
      if (!proto_err && !outchk_err) begin // R6 R7
        body = {spi_resp_pkg::CMD_RD_RSP, basic_flags, 2'h0, reg_pair}; // R1 R12 R9
      end
    end else if (sense_req && !proto_err && !outchk_err) begin
      body = {sense_cmd, (detail_flags != spi_resp_pkg::DETAIL_NONE) ? spi_resp_pkg::FLAGS_ERR : basic_flags,
              sample_value, sample_ext, detail_flags}; // R2
    end
  end

  // whole state update
  always_comb begin
    st_nxt        = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[0], sclk};
    st_nxt.sel_s  = {st_r.sel_s[0], sel_n};
    st_nxt.mosi_s = {st_r.mosi_s[0], mosi};
    st_nxt.sclk_d = st_r.sclk_s[1];
    st_nxt.sel_d  = st_r.sel_s[1];
    st_nxt.done   = 1'b0;
    if (start) begin
      st_nxt.cnt  = '0;
      st_nxt.oe   = 1'b1;
      st_nxt.miso = st_r.tx[31]; // R10
    end
    if (rise && st_r.cnt < 6'(spi_resp_pkg::FRAME_BITS)) begin
      st_nxt.rx  = {st_r.rx[30:0], st_r.mosi_s[1]}; // R10
      st_nxt.cnt = st_r.cnt + 6'h01;
    end
    if (fall && st_r.cnt != '0) begin
      st_nxt.tx   = {st_r.tx[30:0], 1'b0};
      st_nxt.miso = st_r.tx[30];
    end
    // latch the read address while the frame is still open
    if (st_r.cnt == 6'(spi_resp_pkg::FRAME_BITS)) begin
      st_nxt.addr = st_r.rx[spi_resp_pkg::ADDR_HI:spi_resp_pkg::ADDR_LO]; // R4
    end
    if (stop) begin
      st_nxt.oe   = 1'b0;
      st_nxt.miso = 1'b0;
      if (st_r.cnt == 6'(spi_resp_pkg::FRAME_BITS)) begin
        st_nxt.tx      = seal(body); // R5 R8 R9
        st_nxt.done    = 1'b1;
      end else begin
        st_nxt.tx = seal({spi_resp_pkg::CMD_ERR, spi_resp_pkg::FLAGS_ERR, 16'h0000, err_detail}); // R8
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_r         <= '0;
      st_r.sclk_s  <= 2'h0;
      st_r.sel_s   <= 2'h3;
      st_r.sel_d   <= 1'b1;
      st_r.tx      <= seal({spi_resp_pkg::CMD_ERR, spi_resp_pkg::FLAGS_ERR, 16'h0000,
                            spi_resp_pkg::DETAIL_NONE}); // R15
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign miso       = st_r.miso;
  assign miso_oe    = st_r.oe;
  assign reg_addr   = st_r.addr;
  assign frame_done = st_r.done;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_first_err;
    @(posedge ref_clk) disable iff (!nrst)
      $rose(nrst) |-> st_r.tx[31:26] == {spi_resp_pkg::CMD_ERR, spi_resp_pkg::FLAGS_ERR};
  endproperty
  a_first_err: assert property (p_first_err) else $error("reset frame not error layout"); // R15

  property p_read_ok;
    @(posedge ref_clk) disable iff (!nrst)
      (clk_en && stop && st_r.cnt == 6'(spi_resp_pkg::FRAME_BITS) && st_r.rx[31:28] == spi_resp_pkg::CMD_RD_REQ
       && !proto_err && !outchk_err)
      |=> st_r.tx[31:28] == spi_resp_pkg::CMD_RD_RSP && st_r.tx[25:24] == 2'h0
          && st_r.tx[23:8] == $past(reg_pair);
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("read answer wrong"); // R1

  property p_err_resp;
    @(posedge ref_clk) disable iff (!nrst)
      (clk_en && stop && st_r.cnt == 6'(spi_resp_pkg::FRAME_BITS) && st_r.rx[31:28] == spi_resp_pkg::CMD_RD_REQ
       && (proto_err || outchk_err))
      |=> st_r.tx[31:26] == {spi_resp_pkg::CMD_ERR, spi_resp_pkg::FLAGS_ERR} && st_r.tx[25:10] == 16'h0000
          && st_r.tx[9:8] == $past(err_detail);
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("error answer wrong"); // R8

  property p_crc;
    @(posedge ref_clk) disable iff (!nrst)
      $past(stop && clk_en) |-> st_r.tx[7:0] == crc24(st_r.tx[31:8]);
  endproperty
  a_crc: assert property (p_crc) else $error("crc mismatch"); // R14

  property p_idle_quiet;
    @(posedge ref_clk) disable iff (!nrst)
      (st_r.sel_s[1] && st_r.sel_d && clk_en) |=> $stable(st_r.rx) && $stable(st_r.cnt);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("activity while deselected"); // R13

  property p_oe_frame;
    @(posedge ref_clk) disable iff (!nrst)
      (clk_en && stop) |=> !miso_oe && !miso;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("miso driven after frame"); // R10

  property p_addr;
    @(posedge ref_clk) disable iff (!nrst)
      (clk_en && st_r.cnt == 6'(spi_resp_pkg::FRAME_BITS))
      |=> reg_addr == $past(st_r.rx[spi_resp_pkg::ADDR_HI:spi_resp_pkg::ADDR_LO]);
  endproperty
  a_addr: assert property (p_addr) else $error("word address wrong"); // R4

  property p_sense_err;
    @(posedge ref_clk) disable iff (!nrst)
      (clk_en && stop && st_r.cnt == 6'(spi_resp_pkg::FRAME_BITS) && st_r.rx[31:28] != spi_resp_pkg::CMD_RD_REQ
       && sense_req && !proto_err && !outchk_err && detail_flags != spi_resp_pkg::DETAIL_NONE)
      |=> st_r.tx[27:26] == spi_resp_pkg::FLAGS_ERR;
  endproperty
  a_sense_err: assert property (p_sense_err) else $error("sensor error flags not 11"); // R2

endmodule : spi_read_response_framer

/* src/spi_resp_pkg.sv */
// constants for the 32-bit spi response framer
package spi_resp_pkg;
  localparam int          FRAME_BITS    = 32;
  localparam int          CNT_W         = 6;
  localparam logic [3:0]  CMD_RD_REQ    = 4'hC;   // register read request code
  localparam logic [3:0]  CMD_RD_RSP    = 4'h6;   // register read response code
  localparam logic [3:0]  CMD_ERR       = 4'h0;   // error response code
  localparam logic [1:0]  FLAGS_ERR     = 2'h3;   // basic flags on error
  localparam int          CMD_HI        = 31;
  localparam int          CMD_LO        = 28;
  localparam int          ADDR_HI       = 23;
  localparam int          ADDR_LO       = 17;     // upper seven address bits
  localparam int          CRC_LO        = 8;
  localparam logic [7:0]  CRC_POLY_DEF  = 8'h2F;
  localparam logic [7:0]  CRC_SEED_DEF  = 8'hFF;
  localparam logic [1:0]  DETAIL_NONE   = 2'h0;
endpackage : spi_resp_pkg

/* test/spi_host_model.sv */
// spi host model that clocks mode 0 frames of up to 32 bits, msb first
`timescale 1ns/1ps
module spi_host_model (
  // spi pins
  output logic      sclk,
  output logic      sel_n,
  output logic      mosi,
  input  wire logic miso
);
  // idle: clock low, select high
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b0;
  end
  //////////////////////////////
  // one frame of n bits: shift tx out on falls, sample rx on rises
  task automatic xfer_n(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h00000000;
    sel_n = 1'b0;
    for (int i = 31; i >= 32 - n; i--) begin
      mosi = tx[i];
      #32 sclk = 1'b1;
      rx[i] = miso;
      #32 sclk = 1'b0;
    end
    #32 sel_n = 1'b1;
    mosi = ~mosi; // stale data never lingers
    #64;
  endtask : xfer_n
  // full 32-bit frame
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    xfer_n(32, tx, rx);
  endtask : xfer
  // clock and data toggles while deselected, ending idle low
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      mosi = ~mosi;
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #64;
  endtask : idle_clocks
endmodule : spi_host_model

/* test/spi_read_response_framer_tb.sv */
// self-checking bench for the spi response framer
`timescale 1ns/1ps
module spi_read_response_framer_tb;
  logic        ref_clk, nrst, clk_en, sclk, sel_n, mosi, miso, miso_oe, frame_done;
  logic        sense_req, proto_err, outchk_err;
  logic [1:0]  basic_flags, detail_flags, err_detail;
  logic [6:0]  reg_addr;
  logic [15:0] reg_pair, bank;
  logic [31:0] exp_r;
  int          num_errors, comparisons, cycles, frames;
  // register pair model: high byte 1 then address, low byte 0 then address, xor bank
  assign reg_pair = {1'b1, reg_addr, 1'b0, reg_addr} ^ bank;
  spi_read_response_framer u_dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .sclk(sclk), .sel_n(sel_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .reg_addr(reg_addr), .reg_pair(reg_pair),
    .sense_req(sense_req), .sense_cmd(4'h3), .basic_flags(basic_flags), .sample_value(12'hABC),
    .sample_ext(4'h0), .detail_flags(detail_flags), .proto_err(proto_err), .outchk_err(outchk_err),
    .err_detail(err_detail), .frame_done(frame_done));
  spi_host_model u_host (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso));
  //////////////////////////////
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // frame counter and watchdog
  always @(posedge ref_clk) begin
    cycles++;
    if (frame_done === 1'b1) frames++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // appends crc over bits 31..8
  function automatic logic [31:0] frm(input logic [23:0] d);
    logic [7:0] c;
    c = spi_resp_pkg::CRC_SEED_DEF;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? spi_resp_pkg::CRC_POLY_DEF : 8'h00);
    return {d, c};
  endfunction : frm
  function automatic logic [31:0] rd(input logic [7:0] a);
    return frm({4'hC, 4'h0, a, 8'h00});
  endfunction : rd
  function automatic logic [31:0] rsp(input logic [6:0] a);
    return frm({4'h6, basic_flags, 2'h0, {1'b1, a, 1'b0, a} ^ bank});
  endfunction : rsp
  function automatic logic [31:0] errf(input logic [1:0] d);
    return frm({4'h0, 2'h3, 16'h0000, d});
  endfunction : errf
  task automatic check(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // one frame: checks the answer to the previous one
  task automatic step(input string name, input logic [31:0] tx, nx);
    logic [31:0] rx;
    int f0;
    f0 = frames;
    u_host.xfer(tx, rx);
    check(name, exp_r, rx);
    check("frame_done", f0 + 1, frames);
    check("miso_oe", 32'h0, miso_oe);
    exp_r = nx;
    $display("test %s done", name);
  endtask : step
  // select high: clock and data toggles must leave the block untouched
  task automatic quiet_test();
    logic [6:0] a0;
    int         f0;
    a0 = reg_addr;
    f0 = frames;
    u_host.idle_clocks(8);
    check("reg_addr idle", a0, reg_addr);
    check("frame_done idle", f0, frames);
    check("miso_oe idle", 32'h0, miso_oe);
    $display("test quiet done");
  endtask : quiet_test
  // clock enable low: a whole frame passes unseen and the loaded answer stays
  task automatic freeze_test();
    logic [31:0] rx;
    logic [6:0]  a0;
    int          f0;
    @(posedge ref_clk) #1;
    clk_en = 1'b0;
    a0 = reg_addr;
    f0 = frames;
    u_host.xfer(rd(8'h7E), rx);
    check("frozen miso", 32'h0, rx);
    check("frozen frame_done", f0, frames);
    check("frozen reg_addr", a0, reg_addr);
    @(posedge ref_clk) #1;
    clk_en = 1'b1;
    $display("test freeze done");
  endtask : freeze_test
  // a 16-bit frame is refused: no frame event, error answer next
  task automatic short_test();
    logic [31:0] rx;
    int          f0;
    @(posedge ref_clk) #1;
    f0 = frames;
    u_host.xfer_n(16, rd(8'h22), rx);
    check("short", {exp_r[31:16], 16'h0000}, rx);
    check("frame_done short", f0, frames);
    exp_r = errf(err_detail);
    $display("test short done");
  endtask : short_test
  task automatic stop_test();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    sense_req = 1'b0;
    proto_err = 1'b0;
    outchk_err = 1'b0;
    basic_flags = 2'h1;
    detail_flags = 2'h0;
    err_detail = 2'h0;
    bank = 16'h0000;
    exp_r = errf(2'h0);
    repeat (8) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    step("first", rd(8'h35), rsp(7'h1A));
    check("reg_addr", 32'h1A, reg_addr);
    step("read", rd(8'h34), rsp(7'h1A));
    quiet_test();
    @(posedge ref_clk) #1;
    bank = 16'h5AA5;
    step("sampled", rd(8'h03), rsp(7'h01));
    freeze_test();
    for (int k = 1; k <= 2; k++) begin
      @(posedge ref_clk) #1;
      proto_err = (k == 1);
      outchk_err = (k == 2);
      err_detail = k[1:0];
      step("read error", rd(8'h40), errf(k[1:0]));
    end
    @(posedge ref_clk) #1;
    proto_err = 1'b0;
    outchk_err = 1'b0;
    sense_req = 1'b1;
    step("sense", frm({4'h3, 20'h0}), frm({4'h3, 2'h1, 12'hABC, 4'h0, 2'h0}));
    @(posedge ref_clk) #1;
    detail_flags = 2'h2;
    step("sense flags", frm({4'h3, 20'h0}), frm({4'h3, 2'h3, 12'hABC, 4'h0, 2'h2}));
    @(posedge ref_clk) #1;
    sense_req = 1'b0;
    short_test();
    step("flush", rd(8'h00), 32'h0);
    stop_test();
  end
endmodule : spi_read_response_framer_tb
